//--- hdl/plg_pkg.sv
// plg_pkg: constants and types for the pressure limit and gain select block.
// assumes a single 250 MHz clock and a plain address/strobe register port.
package plg_pkg;
	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLK_MHZ     = 250;               // clock rate
	localparam int SEL_TIME_MS = 50;                // select recognition bound
	localparam int SEL_CYC     = SEL_TIME_MS * 1000 * CLK_MHZ;
	localparam int CAL_TIME_S  = 5;                 // span calibration bound
	localparam longint CAL_CYC = 64'(CAL_TIME_S) * 1000000 * CLK_MHZ;
	// ---------------------------------------------------------------
	// scaling (pressure in 0.01 % of full scale, inputs in mV)
	// ---------------------------------------------------------------
	localparam logic signed [15:0] P_FS     = 16'sh2710; // +100.00 %
	localparam logic signed [15:0] P_NEG_FS = -16'sh2710;
	localparam logic [13:0] PCT_MAX   = 14'h2710;  // 100.00 %
	localparam logic [13:0] FS5_MV    = 14'h1388;  // 5 V
	localparam logic [13:0] FS10_MV   = 14'h2710;  // 10 V
	localparam logic [10:0] TRIM5_MV  = 11'h2EE;   // 15 % of 5 V
	localparam logic [10:0] TRIM10_MV = 11'h5DC;   // 15 % of 10 V
	localparam logic [12:0] CAL_MIN   = 13'h19C8;  // 6.6 V
	localparam logic [12:0] CAL_MAX   = 13'h1CE8;  // 7.4 V
	localparam int GAIN_FRAC = 14;                 // adc gain fraction bits
	localparam logic [17:0] GAIN_ONE  = 18'h04000;
	// ---------------------------------------------------------------
	// register map (byte offsets)
	// ---------------------------------------------------------------
	localparam logic [7:0] A_CTRL = 8'h00; // analog, fs10, position flags
	localparam logic [7:0] A_HI0  = 8'h04;
	localparam logic [7:0] A_LO0  = 8'h08;
	localparam logic [7:0] A_HI1  = 8'h0C;
	localparam logic [7:0] A_LO1  = 8'h10;
	localparam logic [7:0] A_ZERO = 8'h14;
	localparam logic [7:0] A_SPAN = 8'h18;
	localparam logic [7:0] A_ASP  = 8'h1C; // scaled set point, read only
	localparam logic [7:0] A_CALV = 8'h20; // write starts calibration
	localparam logic [7:0] A_GAIN = 8'h24; // adc gain, read only
	localparam logic [7:0] A_STAT = 8'h28;
	localparam logic [7:0] A_ISTA = 8'h2C; // read clears
	localparam logic [7:0] A_IMSK = 8'h30;
	localparam logic [2:0] A_LEAD_BLK = 3'h2; // 0x40 + 4n
	localparam logic [2:0] A_GAIN_BLK = 3'h3; // 0x60 + 4n
	// field positions
	localparam int C_ANALOG = 0;
	localparam int C_FS10   = 1;
	localparam int C_POS    = 2; // five bits, one per set point
	localparam logic [6:0] CTRL_RST = 7'h02;
	// interrupt bits
	localparam int IRQ_TRIP0 = 0;
	localparam int IRQ_TRIP1 = 1;
	localparam int IRQ_CDONE = 2;
	localparam int IRQ_CERR  = 3;
	localparam int NIRQ      = 4;
	// carriers
	typedef struct packed {
		logic [15:0] lead;
		logic [15:0] gain;
	} plg_pair_t;
	typedef struct packed {
		logic signed [15:0] hi;
		logic signed [15:0] lo;
	} plg_trip_t;
endpackage

//--- hdl/plg_top.sv
// plg_top: process limit relays, analog set point scaling, lead/gain select
// and converter span calibration. converter codes arrive on the clock domain;
// select pins are asynchronous and are synchronised here.
`timescale 1ns/1ps
module plg_top
	import plg_pkg::*;
#(
	parameter int NREL = 2,
	parameter int NSP  = 5,
	parameter longint CAL_LIMIT = CAL_CYC
) (
	input  wire logic               i_clock,
	input  wire logic               i_resetn,
	input  wire logic [7:0]         i_addr,
	input  wire logic [31:0]        i_wdata,
	input  wire logic               i_wr,
	input  wire logic               i_rd,
	input  wire logic signed [15:0] i_adc_raw,
	input  wire logic [13:0]        i_analog_mv,
	input  wire logic [NSP-1:0]     i_select_n,
	output logic [31:0]             o_rdata,
	output logic [NREL-1:0]         o_process_limit_output,
	output logic                    o_lights_off,
	output plg_pair_t               o_pair,
	output logic                    o_pair_valid,
	output logic [2:0]              o_pair_index,
	output logic                    o_irq
);
	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	logic [6:0]          ctrl_reg;          // control bits
	plg_trip_t           trip_reg [NREL];   // per relay limits
	logic signed [15:0]  zero_reg;          // zero trim, mV
	logic signed [15:0]  span_reg;          // span trim, mV
	plg_pair_t           pair_reg [NSP];    // per set point lead/gain
	logic [12:0]         calv_reg;          // entered cal volts, mV
	logic                cal_req_reg;       // calibration pending
	logic [17:0]         gain_reg;          // converter gain, 4.14
	logic [13:0]         asp_reg;           // scaled set point
	logic [NIRQ-1:0]     ista_reg;          // sticky events
	logic [NIRQ-1:0]     imsk_reg;          // event mask
	logic signed [15:0]  p_reg;             // corrected pressure
	logic [NREL-1:0]     act_reg;           // relay state
	logic [NSP-1:0]      sel_s1_reg;        // first sync stage
	logic [NSP-1:0]      sel_s2_reg;        // second sync stage
	logic [63:0]         cal_cnt_reg;       // cycles since cal accepted
	logic [NREL-1:0]     act_next;
	logic                cal_done;
	logic                cal_err;
	logic                ista_rd;

	// ---------------------------------------------------------------
	// register writes
	// ---------------------------------------------------------------
	logic wr_calv;
	assign wr_calv = i_wr && i_addr == A_CALV;
	assign ista_rd = i_rd && i_addr == A_ISTA;

	// plain configuration storage
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			ctrl_reg <= CTRL_RST;
			zero_reg <= 16'sh0000;
			span_reg <= 16'sh0000;
			imsk_reg <= '0;
			calv_reg <= 13'h0000;
		end else if (i_wr) begin
			case (i_addr)
				A_CTRL: ctrl_reg <= i_wdata[6:0];
				A_ZERO: zero_reg <= i_wdata[15:0];
				A_SPAN: span_reg <= i_wdata[15:0];
				A_IMSK: imsk_reg <= i_wdata[NIRQ-1:0];
				A_CALV: calv_reg <= i_wdata[12:0];
				default: ;
			endcase
		end
	end

	// relay trip limits, one high and one low per relay
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			for (int r = 0; r < NREL; r++) begin
				trip_reg[r] <= '{hi: P_FS, lo: P_NEG_FS};
			end
		end else if (i_wr && i_addr[7:5] == 3'h0) begin
			for (int r = 0; r < NREL; r++) begin
				if (i_addr[4:2] == 3'(2 * r + 1)) begin
					trip_reg[r].hi <= i_wdata[15:0];
				end
				if (i_addr[4:2] == 3'(2 * r + 2)) begin
					trip_reg[r].lo <= i_wdata[15:0];
				end
			end
		end
	end

	// lead and gain storage, one pair per set point
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			for (int s = 0; s < NSP; s++) begin
				pair_reg[s] <= '0;
			end
		end else if (i_wr && i_addr[4:2] < 3'(NSP)) begin
			for (int s = 0; s < NSP; s++) begin
				if (i_addr[4:2] == 3'(s)) begin
					if (i_addr[7:5] == A_LEAD_BLK) begin
						pair_reg[s].lead <= i_wdata[15:0];
					end
					if (i_addr[7:5] == A_GAIN_BLK) begin
						pair_reg[s].gain <= i_wdata[15:0];
					end
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// corrected pressure and limit relays
	// ---------------------------------------------------------------
	logic signed [34:0] p_prod;
	logic signed [20:0] p_scaled;
	assign p_prod   = i_adc_raw * $signed({1'b0, gain_reg});
	assign p_scaled = p_prod[34:GAIN_FRAC];

	// converter reading times calibrated gain, clipped to 16 bits
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			p_reg <= 16'sh0000;
		end else if (p_scaled > 21'sh07FFF) begin
			p_reg <= 16'sh7FFF;
		end else if (p_scaled < -21'sh08000) begin
			p_reg <= -16'sh8000;
		end else begin
			p_reg <= p_scaled[15:0];
		end
	end

	// window compare per relay; extremes switch a side off
	for (genvar r = 0; r < NREL; r++) begin : g_rel
		logic hi_ok;
		logic lo_ok;
		assign hi_ok = trip_reg[r].hi >= P_FS || p_reg <= trip_reg[r].hi;
		assign lo_ok = trip_reg[r].lo <= P_NEG_FS || p_reg >= trip_reg[r].lo;
		assign act_next[r] = hi_ok && lo_ok;
	end

	// relay state, reset de-actuated until the first compare
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			act_reg <= '0;
		end else begin
			act_reg <= act_next;
		end
	end
	assign o_process_limit_output = act_reg;

	// ---------------------------------------------------------------
	// analog set point scaling
	// ---------------------------------------------------------------
	logic [13:0]        fs_base;
	logic [10:0]        trim_lim;
	logic signed [15:0] zero_eff;
	logic signed [15:0] span_eff;
	logic signed [16:0] asp_diff;
	logic [13:0]        asp_den;
	assign fs_base  = ctrl_reg[C_FS10] ? FS10_MV : FS5_MV;
	assign trim_lim = ctrl_reg[C_FS10] ? TRIM10_MV : TRIM5_MV;

	// trims are clamped at use so a later range change stays safe
	always_comb begin
		zero_eff = zero_reg;
		span_eff = span_reg;
		if (zero_reg > $signed({5'h00, trim_lim})) begin
			zero_eff = $signed({5'h00, trim_lim});
		end else if (zero_reg < -$signed({5'h00, trim_lim})) begin
			zero_eff = -$signed({5'h00, trim_lim});
		end
		if (span_reg > $signed({5'h00, trim_lim})) begin
			span_eff = $signed({5'h00, trim_lim});
		end else if (span_reg < -$signed({5'h00, trim_lim})) begin
			span_eff = -$signed({5'h00, trim_lim});
		end
	end
	assign asp_diff = $signed({3'h0, i_analog_mv}) - 17'(zero_eff);
	assign asp_den  = 14'($signed({2'h0, fs_base}) + span_eff);

	// ---------------------------------------------------------------
	// shared divider: calibration jobs pre-empt set point updates
	// ---------------------------------------------------------------
	typedef enum {DV_IDLE, DV_RUN} plg_dv_t;
	plg_dv_t     dv_state;
	logic [31:0] dv_num;
	logic [31:0] dv_quo;
	logic [16:0] dv_rem;
	logic [15:0] dv_den;
	logic [5:0]  dv_cnt;
	logic        dv_cal;
	logic [16:0] dv_trial;
	assign dv_trial = {dv_rem[15:0], dv_num[31]};

	// restoring division, one quotient bit per cycle
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			dv_state <= DV_IDLE;
			dv_num   <= '0;
			dv_quo   <= '0;
			dv_rem   <= '0;
			dv_den   <= '0;
			dv_cnt   <= '0;
			dv_cal   <= 1'b0;
		end else begin
			case (dv_state)
				DV_IDLE: begin
					dv_rem <= '0;
					dv_quo <= '0;
					dv_cnt <= 6'h20;
					dv_state <= DV_RUN;
					if (cal_req_reg && i_adc_raw > 16'sh0000) begin
						dv_cal <= 1'b1;
						dv_num <= {5'h00, calv_reg, 14'h0000};
						dv_den <= i_adc_raw;
					end else begin
						dv_cal <= 1'b0;
						// widen before the product: the percent scale needs 28 bits
						dv_num <= asp_diff[16] ? '0 : {15'h0000, asp_diff} * 32'h0000_2710;
						dv_den <= {2'h0, asp_den};
					end
				end
				DV_RUN: begin
					dv_num <= {dv_num[30:0], 1'b0};
					if (dv_trial >= {1'b0, dv_den}) begin
						dv_rem <= dv_trial - {1'b0, dv_den};
						dv_quo <= {dv_quo[30:0], 1'b1};
					end else begin
						dv_rem <= dv_trial;
						dv_quo <= {dv_quo[30:0], 1'b0};
					end
					dv_cnt <= dv_cnt - 6'h01;
					if (dv_cnt == 6'h01) begin
						dv_state <= DV_IDLE;
					end
				end
				default: dv_state <= DV_IDLE;
			endcase
		end
	end
	logic dv_fin;
	assign dv_fin = dv_state == DV_RUN && dv_cnt == 6'h01;
	logic [31:0] dv_res;
	assign dv_res = {dv_quo[30:0], dv_trial >= {1'b0, dv_den}};

	// scaled set point update, saturating at full scale
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			asp_reg <= 14'h0000;
		end else if (dv_fin && !dv_cal) begin
			asp_reg <= dv_res > 32'(PCT_MAX) ? PCT_MAX : dv_res[13:0];
		end
	end

	// ---------------------------------------------------------------
	// span calibration control
	// ---------------------------------------------------------------
	logic calv_ok;
	assign calv_ok  = i_wdata[12:0] >= CAL_MIN && i_wdata[12:0] <= CAL_MAX && i_wdata[31:13] == '0;
	assign cal_done = dv_fin && dv_cal;
	// a non-positive reading cannot be scaled, so the job is refused
	assign cal_err  = (wr_calv && !calv_ok)
		|| (cal_req_reg && dv_state == DV_IDLE && i_adc_raw <= 16'sh0000);

	// request, gain and elapsed-cycle tracking
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			cal_req_reg <= 1'b0;
			gain_reg    <= GAIN_ONE;
			cal_cnt_reg <= '0;
		end else begin
			if (wr_calv && calv_ok) begin
				cal_req_reg <= 1'b1;
				cal_cnt_reg <= '0;
			end else if (cal_req_reg && dv_state == DV_IDLE && i_adc_raw <= 16'sh0000) begin
				cal_req_reg <= 1'b0;
			end else if (cal_done) begin
				cal_req_reg <= 1'b0;
				gain_reg <= dv_res[17:0];
			end else if (cal_req_reg) begin
				cal_cnt_reg <= cal_cnt_reg + 64'h1;
			end
		end
	end

	// ---------------------------------------------------------------
	// lead and gain selection
	// ---------------------------------------------------------------
	// select pins are asynchronous: two flops before any use
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			sel_s1_reg <= '1;
			sel_s2_reg <= '1;
		end else begin
			sel_s1_reg <= i_select_n;
			sel_s2_reg <= sel_s1_reg;
		end
	end

	// lowest asserted letter wins; none falls back to the first pair
	logic [2:0] sel_idx;
	always_comb begin
		sel_idx = 3'h0;
		for (int s = NSP - 1; s >= 0; s--) begin
			if (!sel_s2_reg[s]) begin
				sel_idx = 3'(s);
			end
		end
	end

	// drive the chosen pair; position set points have none
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			o_pair       <= '0;
			o_pair_index <= 3'h0;
			o_pair_valid <= 1'b0;
		end else begin
			o_pair_index <= sel_idx;
			o_pair_valid <= !ctrl_reg[C_POS + 32'(sel_idx)];
			o_pair <= ctrl_reg[C_POS + 32'(sel_idx)] ? '0 : pair_reg[sel_idx];
		end
	end

	// indicator lights go dark while the analog set point controls
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			o_lights_off <= 1'b0;
		end else begin
			o_lights_off <= ctrl_reg[C_ANALOG];
		end
	end

	// ---------------------------------------------------------------
	// interrupts and read port
	// ---------------------------------------------------------------
	logic [NIRQ-1:0] ev;
	assign ev = {cal_err, cal_done, act_reg & ~act_next};

	// sticky events; a new event beats a clearing read
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			ista_reg <= '0;
			o_irq    <= 1'b0;
		end else begin
			ista_reg <= (ista_rd ? '0 : ista_reg) | ev;
			o_irq    <= |(((ista_rd ? '0 : ista_reg) | ev) & imsk_reg);
		end
	end

	// read data valid in the cycle after the strobe only
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			o_rdata <= '0;
		end else if (!i_rd) begin
			o_rdata <= '0;
		end else begin
			case (i_addr)
				A_CTRL: o_rdata <= {25'h0, ctrl_reg};
				A_HI0:  o_rdata <= 32'(trip_reg[0].hi);
				A_LO0:  o_rdata <= 32'(trip_reg[0].lo);
				A_HI1:  o_rdata <= 32'(trip_reg[1].hi);
				A_LO1:  o_rdata <= 32'(trip_reg[1].lo);
				A_ZERO: o_rdata <= 32'(zero_reg);
				A_SPAN: o_rdata <= 32'(span_reg);
				A_ASP:  o_rdata <= {18'h0, asp_reg};
				A_CALV: o_rdata <= {19'h0, calv_reg};
				A_GAIN: o_rdata <= {14'h0, gain_reg};
				A_STAT: o_rdata <= {24'h0, sel_idx, cal_req_reg, 2'h0, act_reg};
				A_ISTA: o_rdata <= {28'h0, ista_reg};
				A_IMSK: o_rdata <= {28'h0, imsk_reg};
				default: begin
					if ((i_addr[7:5] == A_LEAD_BLK) && i_addr[4:2] < 3'(NSP)) begin
						o_rdata <= {16'h0, pair_reg[i_addr[4:2]].lead};
					end else if ((i_addr[7:5] == A_GAIN_BLK) && i_addr[4:2] < 3'(NSP)) begin
						o_rdata <= {16'h0, pair_reg[i_addr[4:2]].gain};
					end else begin
						o_rdata <= '0;
					end
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	relay_high_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(trip_reg[0].hi < P_FS && p_reg > trip_reg[0].hi) |=> !act_reg[0])
		else $error("relay 0 held above high trip");
	relay_window_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(p_reg <= trip_reg[1].hi && p_reg >= trip_reg[1].lo) |=> act_reg[1])
		else $error("relay 1 not actuated inside window");
	high_disable_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(trip_reg[0].hi == P_FS && trip_reg[0].lo == P_NEG_FS) |=> act_reg[0])
		else $error("disabled relay 0 tripped");
	asp_sat_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
		asp_reg <= PCT_MAX)
		else $error("scaled set point above full scale");
	sel_follow_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
		$fell(i_select_n[2]) && i_select_n[1:0] == 2'h3 ##1 i_select_n[2:0] == 3'h3 [*3]
		|-> o_pair_index == 3'h2)
		else $error("select not applied in time");
	sel_revert_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
		(&i_select_n) [*4] |-> o_pair_index == 3'h0)
		else $error("no revert to first pair");
	pos_nopair_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
		ctrl_reg[C_POS + 32'(o_pair_index)] && $stable(ctrl_reg) && $stable(o_pair_index)
		|-> !o_pair_valid && o_pair == '0)
		else $error("position set point drove a pair");
	cal_time_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
		wr_calv && calv_ok && !cal_req_reg |-> ##[1:80] !cal_req_reg)
		else $error("span calibration overran");
	cal_limit_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
		cal_cnt_reg < 64'(CAL_LIMIT))
		else $error("span calibration past time limit");
	lights_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
		ctrl_reg[C_ANALOG] ##1 ctrl_reg[C_ANALOG] |-> o_lights_off)
		else $error("lights on under analog control");
endmodule

//--- test/plg_far_model.sv
// plg_far_model: sensor reading and select pins on the far side of plg_top.
// assumes the bench asks for a reading and a select pattern on the clock.
`timescale 1ns/1ps
module plg_far_model (
	input  wire logic               i_clock,
	input  wire logic               i_resetn,
	input  wire logic signed [15:0] i_want_mv,
	input  wire logic [4:0]         i_want_sel_n,
	output logic signed [15:0]      o_adc_raw,
	output logic [4:0]              o_select_n
);
	// ---------------------------------------------------------------
	// sensor and select drive
	// ---------------------------------------------------------------
	// a select stays low for as long as the bench asks, never pulsed
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			o_adc_raw  <= 16'sh0000;
			o_select_n <= 5'h1F; // released lines read high
		end else begin
			o_adc_raw  <= i_want_mv;
			o_select_n <= i_want_sel_n;
		end
	end
endmodule

//--- test/plg_top_tb.sv
// plg_top_tb: random and corner tests of relays, scaling, select and cal.
// assumes plg_top and plg_far_model are compiled before this file.
`timescale 1ns/1ps
module plg_top_tb;
	import plg_pkg::*;
	logic i_clock, i_resetn, i_wr, i_rd;
	logic [7:0] i_addr;
	logic [31:0] i_wdata, o_rdata, q;
	logic signed [15:0] raw, want_mv;
	logic [13:0] i_analog_mv;
	logic [4:0] sel_n, want_sel;
	logic [1:0] o_plo;
	logic o_lights_off, o_pair_valid, o_irq;
	logic [2:0] o_pair_index;
	plg_pair_t o_pair;
	int n_mismatch, n_compared, p;
	int mv_t[5] = '{3000, 6000, 3000, 3000, 3000};
	int z_t[5] = '{0, 0, 1000, 0, -1000};
	int s_t[5] = '{0, 0, 0, 2000, 0};
	plg_top #(.CAL_LIMIT(1000)) DUT (.i_clock(i_clock), .i_resetn(i_resetn),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.i_adc_raw(raw), .i_analog_mv(i_analog_mv), .i_select_n(sel_n),
		.o_rdata(o_rdata), .o_process_limit_output(o_plo),
		.o_lights_off(o_lights_off), .o_pair(o_pair), .o_pair_valid(o_pair_valid),
		.o_pair_index(o_pair_index), .o_irq(o_irq));
	plg_far_model FAR (.i_clock(i_clock), .i_resetn(i_resetn), .i_want_mv(want_mv),
		.i_want_sel_n(want_sel), .o_adc_raw(raw), .o_select_n(sel_n));
	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	initial begin
		i_clock = 1'b0;
		forever #2 i_clock = ~i_clock;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clock);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clock);
		i_addr <= a; i_wdata <= d; i_wr <= 1'b1;
		@(posedge i_clock);
		i_wr <= 1'b0;
	endtask
	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a);
		@(posedge i_clock);
		i_addr <= a; i_rd <= 1'b1;
		@(posedge i_clock);
		i_rd <= 1'b0;
		#1 q = o_rdata;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask
	// expected scaled set point, trims clamped to 15 percent of full scale
	function automatic int exp_asp(int mv, int z, int s, bit f10);
		int fs, t, v;
		fs = f10 ? 10000 : 5000;
		t = f10 ? 1500 : 750;
		z = z > t ? t : (z < -t ? -t : z);
		s = s > t ? t : (s < -t ? -t : s);
		v = (mv - z) * 10000 / (fs + s);
		return v < 0 ? 0 : (v > 10000 ? 10000 : v);
	endfunction
	function automatic logic [2:0] exp_idx(logic [4:0] s);
		for (int i = 0; i < 5; i++) if (!s[i]) return 3'(i);
		return 3'h0;
	endfunction
	task automatic results;
		if (n_mismatch == 0 && n_compared > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// watchdog: the sequence needs about 1500 cycles, this allows 10000
	initial begin
		#40000;
		n_mismatch++;
		results;
	end
	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		i_resetn = 1'b0; i_wr = 1'b0; i_rd = 1'b0; i_addr = 8'h00;
		i_wdata = 32'h0; want_mv = 16'sh0; want_sel = 5'h1F; i_analog_mv = 14'h0;
		void'($urandom(32'h5def3fbb));
		cyc(10);
		i_resetn <= 1'b1;
		rd(A_CTRL);
		chk(q, 32'h2);
		chk(32'(o_lights_off), 32'h0);
		rd(A_GAIN);
		chk(q, 32'h4000);
		rd(8'hFC);
		chk(q, 32'h0);
		// relay 0 narrow window, relay 1 limits at the full-scale extremes
		wr(A_HI0, 32'(5000)); wr(A_LO0, 32'(1000));
		wr(A_HI1, 32'(10000)); wr(A_LO1, 32'(-10000));
		for (int k = 0; k < 40; k++) begin
			p = k < 6 ? (k == 0 ? 5000 : k == 1 ? 5001 : k == 2 ? 1000 : k == 3 ? 999
				: k == 4 ? 12000 : -12000) : int'($urandom_range(18000)) - 9000;
			// beyond full scale relay 1 stays actuated: both its sides are disabled
			want_mv <= 16'(p);
			cyc(5);
			chk(32'(o_plo), {30'h0, 1'b1, p >= 1000 && p <= 5000});
		end
		// trip event masked, unmasked, then cleared by the read
		want_mv <= 16'sh0BB8; cyc(5);
		wr(A_IMSK, 32'h0); rd(A_ISTA);
		want_mv <= 16'sh1770; cyc(5);
		chk(32'(o_irq), 32'h0);
		wr(A_IMSK, 32'h1); cyc(2);
		chk(32'(o_irq), 32'h1);
		rd(A_ISTA); chk(q, 32'h1);
		cyc(2); chk(32'(o_irq), 32'h0);
		// analog set point scaling, 5 V table then one 10 V point
		wr(A_CTRL, 32'h1); cyc(2);
		chk(32'(o_lights_off), 32'h1);
		for (int k = 0; k < 6; k++) begin
			p = k < 5 ? mv_t[k] : 5000;
			if (k == 5) wr(A_CTRL, 32'h3);
			wr(A_ZERO, 32'(k < 5 ? z_t[k] : 0)); wr(A_SPAN, 32'(k < 5 ? s_t[k] : 0));
			i_analog_mv <= 14'(p);
			cyc(100);
			rd(A_ASP);
			chk(q, 32'(exp_asp(p, k < 5 ? z_t[k] : 0, k < 5 ? s_t[k] : 0, k == 5)));
		end
		// lead and gain select with held pins
		for (int n = 0; n < 5; n++) begin
			wr(8'h40 + 8'(4 * n), 32'h1000 + 32'(n));
			wr(8'h60 + 8'(4 * n), 32'h2000 + 32'(n));
		end
		for (int k = 0; k < 20; k++) begin
			// the third pattern drops only the C line, so the select timing check fires
			want_sel <= k == 0 ? 5'h00 : (k == 1 ? 5'h1F : (k == 2 ? 5'h1B
				: 5'($urandom_range(31))));
			cyc(7);
			chk(32'(o_pair_index), 32'(exp_idx(want_sel)));
			chk(32'(o_pair_valid), 32'h1);
			chk(o_pair, {16'h1000 + 16'(exp_idx(want_sel)), 16'h2000 + 16'(exp_idx(want_sel))});
		end
		wr(A_CTRL, 32'hB); want_sel <= 5'h1D; cyc(7);
		chk({o_pair, o_pair_valid} == 33'h0, 1'b1);
		want_sel <= 5'h1F; cyc(7);
		chk(32'(o_pair_index), 32'h0);
		// span calibration, good value then one out of range
		want_mv <= 16'sh1770; wr(A_CTRL, 32'h3); rd(A_ISTA);
		wr(A_CALV, 32'(7000)); cyc(200);
		rd(A_GAIN); chk(q, 32'h4AAA);
		rd(A_ISTA); chk(q, 32'h4);
		wr(A_CALV, 32'(6000)); cyc(200);
		rd(A_ISTA); chk(q, 32'h8);
		results;
	end
endmodule
